/* ddr_startup_pkg.sv */
package ddr_startup_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int STEP_TIME_NS   = 80;
  localparam int STEP_CYCLES    = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_TIME_NS = 160;
  localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CYCLES  = 4;
  localparam logic [4:0] STEP_LAST   = 5'(STEP_CYCLES - 1);
  localparam logic [4:0] SETTLE_LAST = 5'(SETTLE_CYCLES - 1);
  localparam logic [4:0] SAMPLE_LAST = 5'(SAMPLE_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Aligner figures
  localparam logic [3:0] PLL_LAST_PHASE = 4'hf;
  localparam logic [4:0] PLL_PHASES     = 5'h10;
  localparam logic [4:0] PHASES_PER_BIT = 5'h08;
  localparam logic [4:0] MIN_WINDOW     = 5'h03;
  localparam logic [4:0] SCAN_LAST      = 5'h1f;
  localparam logic [6:0] WORD_TARGET    = 7'h63;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] CMD_OFFSET    = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam int CTRL_GEN_RST     = 0;
  localparam int CTRL_RX_RST      = 1;
  localparam int CTRL_MEM_RST     = 2;
  localparam int CTRL_ALIGN_RST   = 3;
  localparam int CTRL_GEN_START   = 4;
  localparam logic [4:0] CTRL_RESET = 5'h0f;
  localparam int CMD_RX_UPDATE    = 0;
  localparam int CMD_MEM_UPDATE   = 1;
  localparam int CMD_ALIGN_UPDATE = 2;
  localparam int STATUS_GEN_READY   = 0;
  localparam int STATUS_RX_READY    = 1;
  localparam int STATUS_MEM_READY   = 2;
  localparam int STATUS_BIT_LOCK    = 3;
  localparam int STATUS_WORD_LOCK   = 4;
  localparam int STATUS_ALIGN_READY = 5;
  localparam int STATUS_WINDOW_LSB  = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers and states
  typedef struct packed {
    logic stop;
    logic freeze;
    logic delay_code_update_n;
    logic dll_reset;
    logic gearing_reset;
    logic pause;
    logic ready;
  } seq_out_type;

  localparam seq_out_type SEQ_OUT_RESET = 7'b0011100;

  typedef enum logic [2:0] {
    S_WAIT    = 3'h0,
    S_FREEZE  = 3'h1,
    S_STOP    = 3'h3,
    S_RELEASE = 3'h2,
    S_RESUME  = 3'h6,
    S_CODE    = 3'h7,
    S_READY   = 3'h5
  } seq_state_type;

  typedef struct packed {
    seq_state_type st;
    logic [4:0]    cnt;
    seq_out_type   q;
  } seq_reg_type;

  typedef struct packed {
    logic       phase_advance_pulse;
    logic       rotation_sense;
    logic       word_rotate_pulse;
    logic [3:0] window_size;
    logic       bit_lock;
    logic       word_lock;
    logic       ready;
  } align_out_type;

  typedef enum logic [3:0] {
    A_IDLE    = 4'h0,
    A_SETTLE  = 4'h1,
    A_SAMPLE  = 4'h3,
    A_STEP    = 4'h2,
    A_SCAN    = 4'h6,
    A_PICK    = 4'h7,
    A_WSETTLE = 4'h5,
    A_MOVE    = 4'h4,
    A_WCHECK  = 4'hc,
    A_DONE    = 4'hd,
    A_FAIL    = 4'hf
  } align_state_type;

endpackage : ddr_startup_pkg

/* ddr_startup_and_lvds_align.sv */
// Function
// - Generic sequencer reset holds stop low, gearing reset high, ready low.
// - Generic sequencer waits for its start input before synchronising.
// - Generic gearing reset drives all gearing elements and the edge clock divider.
// - Aligned-receive reset: stop, freeze low; code update, loop reset, gearing reset high.
// - Aligned-receive and memory sequencers wait for delay-loop lock.
// - Aligned-receive update drops ready, reruns sync, raises ready when done.
// - Aligned-receive gearing reset drives input gearing and the edge clock divider.
// - Memory sequencer resets like aligned-receive and holds pause low.
// - Memory gearing reset covers all gearing, strobe buffer, divider; drives pause.
// - Memory sequencer accepts update requests once ready is high.
// - Aligner reset drives every aligner output to zero.
// - Aligner starts on update only with PLL lock; update restarts it.
// - Aligner watches the 7-bit clock-lane word.
// - Aligner pulses phase advance with rotation sense held at zero.
// - Bit alignment visits all 16 PLL phases, sampling the clock lane.
// - Phases near transitions are flagged; the phase farthest from them wins.
// - Aligner reports window size, bit lock, word lock and ready.
// - Window is judged against 8 candidate phases per bit period.
// - Each word rotate pulse shifts the word by two bits; seven cover all.
// - Word rotate pulses continue until the word equals 7'h63, then word lock.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Startup sequencer, shared by the three interface kinds
module startup_sequencer #(
  parameter bit HAS_DLL   = 1'b1,
  parameter bit HAS_PAUSE = 1'b0
) (
  // Clock and reset
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  // Control
  input  wire logic                         srst,
  input  wire logic                         start,
  input  wire logic                         update,
  input  wire logic                         dll_lock,
  // Primitive controls
  output ddr_startup_pkg::seq_out_type      q
);

  ddr_startup_pkg::seq_reg_type s;
  ddr_startup_pkg::seq_reg_type next_s;
  logic                         step_done;

  assign q = s.q;

  always_comb begin
    next_s    = s;
    step_done = (s.cnt == ddr_startup_pkg::STEP_LAST);
    next_s.cnt = step_done ? 5'h00 : 5'(s.cnt + 5'h01);
    next_s.q.delay_code_update_n = 1'b1;
    if (srst) begin
      next_s.st  = ddr_startup_pkg::S_WAIT;
      next_s.cnt = 5'h00;
      next_s.q   = ddr_startup_pkg::SEQ_OUT_RESET;
    end else begin
      case (s.st)
        ddr_startup_pkg::S_WAIT: begin
          // Loop reset is let go first so the lock can come up
          next_s.q.dll_reset = 1'b0;
          next_s.cnt         = 5'h00;
          if (start && (!HAS_DLL || dll_lock)) begin
            next_s.st = ddr_startup_pkg::S_FREEZE;
          end
        end
        ddr_startup_pkg::S_FREEZE: begin
          next_s.q.freeze = HAS_DLL;
          next_s.q.pause  = HAS_PAUSE;
          if (step_done) begin
            next_s.st = ddr_startup_pkg::S_STOP;
          end
        end
        ddr_startup_pkg::S_STOP: begin
          next_s.q.stop = 1'b1;
          if (step_done) begin
            next_s.st = ddr_startup_pkg::S_RELEASE;
          end
        end
        ddr_startup_pkg::S_RELEASE: begin
          // Released only while the edge clock is stopped, so dividers start aligned
          next_s.q.gearing_reset = 1'b0;
          if (step_done) begin
            next_s.st = ddr_startup_pkg::S_RESUME;
          end
        end
        ddr_startup_pkg::S_RESUME: begin
          next_s.q.stop = 1'b0;
          if (step_done) begin
            next_s.st = ddr_startup_pkg::S_CODE;
          end
        end
        ddr_startup_pkg::S_CODE: begin
          next_s.q.freeze              = 1'b0;
          next_s.q.delay_code_update_n = !HAS_DLL;
          if (step_done) begin
            next_s.st      = ddr_startup_pkg::S_READY;
            next_s.q.pause = 1'b0;
            next_s.q.ready = 1'b1;
          end
        end
        ddr_startup_pkg::S_READY: begin
          next_s.cnt = 5'h00;
          // Gearing stays out of reset on update so the interface keeps running
          if (update && HAS_DLL) begin
            next_s.q.ready = 1'b0;
            next_s.st      = ddr_startup_pkg::S_FREEZE;
          end
        end
        default: begin
          next_s.st = ddr_startup_pkg::S_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s   <= '0;
      s.q <= ddr_startup_pkg::SEQ_OUT_RESET;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_reset_levels;
    srst |=> (q == ddr_startup_pkg::SEQ_OUT_RESET);
  endproperty
  a_reset_levels: assert property (p_reset_levels)
    else $error("sequencer reset levels wrong");

  property p_start_gate;
    (s.st == ddr_startup_pkg::S_WAIT) ##1 (s.st == ddr_startup_pkg::S_FREEZE)
      |-> $past(start) && ($past(dll_lock) || !HAS_DLL);
  endproperty
  a_start_gate: assert property (p_start_gate)
    else $error("sequence left wait without start or lock");

  property p_ready_order;
    $rose(q.ready) |-> !q.stop && !q.gearing_reset && !q.freeze;
  endproperty
  a_ready_order: assert property (p_ready_order)
    else $error("ready rose before stop and reset steps ended");

  property p_update_drop;
    (q.ready && update && HAS_DLL && !srst) |=> !q.ready ##1 !q.ready;
  endproperty
  a_update_drop: assert property (p_update_drop)
    else $error("ready not dropped on update");

endmodule : startup_sequencer

////////////////////////////////////////////////////////////////////////////////
// Top: register slave, three sequencers and the bit and word aligner
module ddr_startup_and_lvds_align (
  // Clock and reset
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic [31:0]                        hrdata,
  output logic                               hresp,
  // Lock and clock-lane inputs
  input  wire logic                          pll_lock,
  input  wire logic                          rx_dll_lock,
  input  wire logic                          mem_dll_lock,
  input  wire logic [6:0]                    clock_lane_word,
  // Primitive controls
  output ddr_startup_pkg::seq_out_type       gen_ctl,
  output ddr_startup_pkg::seq_out_type       rx_ctl,
  output ddr_startup_pkg::seq_out_type       mem_ctl,
  output ddr_startup_pkg::align_out_type     align_ctl
);

  typedef struct packed {
    logic                              hreadyout;
    logic                              hresp;
    logic [31:0]                       hrdata;
    logic                              ahb_wr;
    logic [7:0]                        ahb_addr;
    logic [4:0]                        ctrl;
    logic [2:0]                        cmd;
    ddr_startup_pkg::align_state_type  ast;
    logic [4:0]                        acnt;
    logic [3:0]                        idx;
    logic [6:0]                        first;
    logic [15:0]                       noisy;
    logic [4:0]                        scan;
    logic [4:0]                        run;
    logic [4:0]                        best;
    logic [3:0]                        best_end;
    logic [3:0]                        moves;
    ddr_startup_pkg::align_out_type    out;
  } top_reg_type;

  top_reg_type s;
  top_reg_type next_s;
  logic [31:0] rd;
  logic [4:0]  run_inc;
  logic [4:0]  len;
  logic [3:0]  tgt;
  logic        settle_done;

  assign hreadyout = s.hreadyout;
  assign hrdata    = s.hrdata;
  assign hresp     = s.hresp;
  assign align_ctl = s.out;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencers
  startup_sequencer #(.HAS_DLL(1'b0), .HAS_PAUSE(1'b0)) u_gen (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .srst     (s.ctrl[ddr_startup_pkg::CTRL_GEN_RST]),
    .start    (s.ctrl[ddr_startup_pkg::CTRL_GEN_START]),
    .update   (1'b0),
    .dll_lock (1'b0),
    .q        (gen_ctl)
  );

  startup_sequencer #(.HAS_DLL(1'b1), .HAS_PAUSE(1'b0)) u_rx (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .srst     (s.ctrl[ddr_startup_pkg::CTRL_RX_RST]),
    .start    (1'b1),
    .update   (s.cmd[ddr_startup_pkg::CMD_RX_UPDATE]),
    .dll_lock (rx_dll_lock),
    .q        (rx_ctl)
  );

  startup_sequencer #(.HAS_DLL(1'b1), .HAS_PAUSE(1'b1)) u_mem (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .srst     (s.ctrl[ddr_startup_pkg::CTRL_MEM_RST]),
    .start    (1'b1),
    .update   (s.cmd[ddr_startup_pkg::CMD_MEM_UPDATE]),
    .dll_lock (mem_dll_lock),
    .q        (mem_ctl)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register slave and aligner
  always_comb begin
    next_s      = s;
    rd          = 32'h0000_0000;
    run_inc     = (s.run == 5'h1f) ? s.run : 5'(s.run + 5'h01);
    len         = (s.best > ddr_startup_pkg::PLL_PHASES) ? ddr_startup_pkg::PLL_PHASES : s.best;
    tgt         = 4'(s.best_end - 4'((5'(len - 5'h01)) >> 1));
    settle_done = (s.acnt == ddr_startup_pkg::SETTLE_LAST);
    next_s.cmd  = 3'h0;
    next_s.out.phase_advance_pulse = 1'b0;
    next_s.out.word_rotate_pulse   = 1'b0;
    next_s.out.rotation_sense      = 1'b0;

    // Zero wait state: read data is fetched in the address phase
    case (haddr[7:0])
      ddr_startup_pkg::CTRL_OFFSET: rd[4:0] = s.ctrl;
      ddr_startup_pkg::STATUS_OFFSET: begin
        rd[ddr_startup_pkg::STATUS_GEN_READY]   = gen_ctl.ready;
        rd[ddr_startup_pkg::STATUS_RX_READY]    = rx_ctl.ready;
        rd[ddr_startup_pkg::STATUS_MEM_READY]   = mem_ctl.ready;
        rd[ddr_startup_pkg::STATUS_BIT_LOCK]    = s.out.bit_lock;
        rd[ddr_startup_pkg::STATUS_WORD_LOCK]   = s.out.word_lock;
        rd[ddr_startup_pkg::STATUS_ALIGN_READY] = s.out.ready;
        rd[ddr_startup_pkg::STATUS_WINDOW_LSB +: 4] = s.out.window_size;
      end
      default: rd = 32'h0000_0000;
    endcase
    if (s.ahb_wr) begin
      case (s.ahb_addr)
        ddr_startup_pkg::CTRL_OFFSET: next_s.ctrl = hwdata[4:0];
        ddr_startup_pkg::CMD_OFFSET:  next_s.cmd  = hwdata[2:0];
        default: ;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      next_s.ahb_wr   = hwrite;
      next_s.ahb_addr = haddr[7:0];
      next_s.hrdata   = hwrite ? 32'h0000_0000 : rd;
    end else begin
      next_s.ahb_wr   = 1'b0;
    end

    if (s.ctrl[ddr_startup_pkg::CTRL_ALIGN_RST]) begin
      next_s.ast = ddr_startup_pkg::A_IDLE;
      next_s.out = '0;
    end else if (s.cmd[ddr_startup_pkg::CMD_ALIGN_UPDATE] && pll_lock) begin
      next_s.ast   = ddr_startup_pkg::A_SETTLE;
      next_s.out   = '0;
      next_s.idx   = 4'h0;
      next_s.noisy = 16'h0000;
      next_s.acnt  = 5'h00;
    end else begin
      case (s.ast)
        ddr_startup_pkg::A_SETTLE: begin
          next_s.acnt  = 5'(s.acnt + 5'h01);
          next_s.first = clock_lane_word;
          if (settle_done) begin
            next_s.acnt = 5'h00;
            next_s.ast  = ddr_startup_pkg::A_SAMPLE;
          end
        end
        ddr_startup_pkg::A_SAMPLE: begin
          next_s.acnt = 5'(s.acnt + 5'h01);
          if (clock_lane_word != s.first) begin
            next_s.noisy[s.idx] = 1'b1;
          end
          if (s.acnt == ddr_startup_pkg::SAMPLE_LAST) begin
            next_s.acnt = 5'h00;
            if (s.idx == ddr_startup_pkg::PLL_LAST_PHASE) begin
              next_s.scan = 5'h00;
              next_s.run  = 5'h00;
              next_s.best = 5'h00;
              next_s.ast  = ddr_startup_pkg::A_SCAN;
            end else begin
              next_s.ast  = ddr_startup_pkg::A_STEP;
            end
          end
        end
        ddr_startup_pkg::A_STEP: begin
          next_s.out.phase_advance_pulse = 1'b1;
          next_s.idx = 4'(s.idx + 4'h1);
          next_s.ast = ddr_startup_pkg::A_SETTLE;
        end
        ddr_startup_pkg::A_SCAN: begin
          // Two passes over the ring so a clean run that wraps is measured whole
          if (!s.noisy[s.scan[3:0]]) begin
            next_s.run = run_inc;
            if (run_inc > s.best) begin
              next_s.best     = run_inc;
              next_s.best_end = s.scan[3:0];
            end
          end else begin
            next_s.run = 5'h00;
          end
          next_s.scan = 5'(s.scan + 5'h01);
          if (s.scan == ddr_startup_pkg::SCAN_LAST) begin
            next_s.ast = ddr_startup_pkg::A_PICK;
          end
        end
        ddr_startup_pkg::A_PICK: begin
          next_s.out.window_size = (len > ddr_startup_pkg::PHASES_PER_BIT) ?
                                   4'(ddr_startup_pkg::PHASES_PER_BIT) : len[3:0];
          if (len >= ddr_startup_pkg::MIN_WINDOW) begin
            next_s.out.bit_lock = 1'b1;
            next_s.moves = 4'(tgt + 4'h1);
            next_s.acnt  = 5'h00;
            next_s.ast   = ddr_startup_pkg::A_WSETTLE;
          end else begin
            next_s.ast   = ddr_startup_pkg::A_FAIL;
          end
        end
        ddr_startup_pkg::A_WSETTLE: begin
          next_s.acnt = 5'(s.acnt + 5'h01);
          if (settle_done) begin
            next_s.acnt = 5'h00;
            next_s.ast  = (s.moves != 4'h0) ? ddr_startup_pkg::A_MOVE :
                                              ddr_startup_pkg::A_WCHECK;
          end
        end
        ddr_startup_pkg::A_MOVE: begin
          next_s.out.phase_advance_pulse = 1'b1;
          next_s.moves = 4'(s.moves - 4'h1);
          next_s.ast   = ddr_startup_pkg::A_WSETTLE;
        end
        ddr_startup_pkg::A_WCHECK: begin
          if (clock_lane_word == ddr_startup_pkg::WORD_TARGET) begin
            next_s.out.word_lock = 1'b1;
            next_s.out.ready     = 1'b1;
            next_s.ast           = ddr_startup_pkg::A_DONE;
          end else begin
            // No give-up count: a bad lane keeps rotating until software restarts
            next_s.out.word_rotate_pulse = 1'b1;
            next_s.ast = ddr_startup_pkg::A_WSETTLE;
          end
        end
        ddr_startup_pkg::A_IDLE, ddr_startup_pkg::A_DONE, ddr_startup_pkg::A_FAIL: ;
        default: next_s.ast = ddr_startup_pkg::A_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s           <= '0;
      s.hreadyout <= 1'b1;
      s.ctrl      <= ddr_startup_pkg::CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_align_reset;
    s.ctrl[ddr_startup_pkg::CTRL_ALIGN_RST] |=> (align_ctl == '0);
  endproperty
  a_align_reset: assert property (p_align_reset)
    else $error("aligner outputs not zero in reset");

  property p_start_lock;
    (s.ast == ddr_startup_pkg::A_IDLE) ##1 (s.ast == ddr_startup_pkg::A_SETTLE)
      |-> $past(pll_lock) && $past(s.cmd[ddr_startup_pkg::CMD_ALIGN_UPDATE]);
  endproperty
  a_start_lock: assert property (p_start_lock)
    else $error("alignment started without lock and update");

  property p_fixed_sense;
    align_ctl.rotation_sense == 1'b0;
  endproperty
  a_fixed_sense: assert property (p_fixed_sense)
    else $error("rotation sense not forward");

  property p_step_spacing;
    align_ctl.phase_advance_pulse |=> !align_ctl.phase_advance_pulse [*8];
  endproperty
  a_step_spacing: assert property (p_step_spacing)
    else $error("phase steps too close");

  property p_window_cap;
    align_ctl.window_size <= 4'(ddr_startup_pkg::PHASES_PER_BIT);
  endproperty
  a_window_cap: assert property (p_window_cap)
    else $error("window beyond one bit period");

  property p_word_lock;
    $rose(align_ctl.word_lock) |-> $past(clock_lane_word) == ddr_startup_pkg::WORD_TARGET;
  endproperty
  a_word_lock: assert property (p_word_lock)
    else $error("word lock without target word");

  property p_rotate_after_bit;
    align_ctl.word_rotate_pulse |-> align_ctl.bit_lock && !align_ctl.word_lock;
  endproperty
  a_rotate_after_bit: assert property (p_rotate_after_bit)
    else $error("word rotation before bit lock");

  property p_ready_locks;
    $rose(align_ctl.ready) |-> align_ctl.bit_lock && align_ctl.word_lock;
  endproperty
  a_ready_locks: assert property (p_ready_locks)
    else $error("aligner ready without both locks");

endmodule : ddr_startup_and_lvds_align

/* far_side_model.sv */
`timescale 1ns/1ns
module far_side_model (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // From the bench and the block
  input  wire logic       lock_en,
  input  wire logic       phase_advance_pulse,
  input  wire logic       word_rotate_pulse,
  // Toward the block
  output logic            pll_lock,
  output logic            rx_dll_lock,
  output logic            mem_dll_lock,
  output logic [6:0]      clock_lane_word
);
  logic [3:0] phase;
  logic [6:0] word;
  logic       tog;
  assign pll_lock     = lock_en;
  assign rx_dll_lock  = lock_en;
  assign mem_dll_lock = lock_en;
  // Two phases sit on the clock edge, so the word flickers every cycle there
  assign clock_lane_word = (phase < 4'h2 && tog) ? ~word : word;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= 4'h0;
      word  <= 7'h0f;
      tog   <= 1'b0;
    end else begin
      tog <= ~tog;
      if (phase_advance_pulse)
        phase <= phase + 4'h1;
      if (word_rotate_pulse)
        word <= {word[4:0], word[6:5]};
    end
  end
endmodule : far_side_model

/* testbench.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        lock_en = 1'b0;
  logic        hreadyout, hresp, pll_lock, rx_dll_lock, mem_dll_lock;
  logic [31:0] hrdata, rd;
  logic [6:0]  clw;
  ddr_startup_pkg::seq_out_type   gen_ctl, rx_ctl, mem_ctl;
  ddr_startup_pkg::align_out_type align_ctl;
  int          err_count = 0;
  int          cmp_count = 0;

  always #5 hclk = ~hclk;

  ddr_startup_and_lvds_align dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pll_lock(pll_lock),
    .rx_dll_lock(rx_dll_lock), .mem_dll_lock(mem_dll_lock), .clock_lane_word(clw),
    .gen_ctl(gen_ctl), .rx_ctl(rx_ctl), .mem_ctl(mem_ctl), .align_ctl(align_ctl));

  far_side_model model_u (
    .hclk(hclk), .hresetn(hresetn), .lock_en(lock_en),
    .phase_advance_pulse(align_ctl.phase_advance_pulse),
    .word_rotate_pulse(align_ctl.word_rotate_pulse), .pll_lock(pll_lock),
    .rx_dll_lock(rx_dll_lock), .mem_dll_lock(mem_dll_lock), .clock_lane_word(clw));

  ////////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
  endtask : wait_ready

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : xfer

  // Polls status; the bound keeps a stuck sequencer from hanging the run
  task wait_bit(input int b, input logic v);
    int n;
    n = 0;
    do begin
      xfer(1'b0, ddr_startup_pkg::STATUS_OFFSET, 32'h0);
      n++;
    end while (rd[b] !== v && n < 600);
    `CHK("status bit", v, rd[b])
  endtask : wait_bit

  ////////////////////////////////////////////////////////////////////////////////
  task check_reset;
    `CHK("gen", ddr_startup_pkg::SEQ_OUT_RESET, gen_ctl)
    `CHK("rx", ddr_startup_pkg::SEQ_OUT_RESET, rx_ctl)
    `CHK("mem", ddr_startup_pkg::SEQ_OUT_RESET, mem_ctl)
    `CHK("align", 10'h0, align_ctl)
    xfer(1'b0, ddr_startup_pkg::CTRL_OFFSET, 32'h0);
    `CHK("ctrl", 32'h0000000f, rd)
    `CHK("hresp", 1'b0, hresp)
  endtask : check_reset

  task seq_startup;
    xfer(1'b1, ddr_startup_pkg::CTRL_OFFSET, 32'h0000000e);
    repeat (60) @(posedge hclk);
    `CHK("gen idle", 2'b01, {gen_ctl.ready, gen_ctl.gearing_reset})
    xfer(1'b1, ddr_startup_pkg::CTRL_OFFSET, 32'h00000018);
    wait_bit(0, 1'b1);
    `CHK("gen run", 2'b00, {gen_ctl.stop, gen_ctl.gearing_reset})
    `CHK("rx no lock", 1'b0, rx_ctl.ready)
    lock_en <= 1'b1;
    wait_bit(1, 1'b1);
    `CHK("rx loop", 2'b01, {rx_ctl.dll_reset, rx_ctl.delay_code_update_n})
    wait_bit(2, 1'b1);
    `CHK("mem run", 3'b000, {mem_ctl.stop, mem_ctl.gearing_reset, mem_ctl.pause})
  endtask : seq_startup

  task updates;
    xfer(1'b1, ddr_startup_pkg::CMD_OFFSET, 32'h00000003);
    wait_bit(1, 1'b0);
    wait_bit(2, 1'b0);
    `CHK("mem pause", 1'b1, mem_ctl.pause)
    `CHK("gen keeps", 1'b1, gen_ctl.ready)
    wait_bit(1, 1'b1);
    wait_bit(2, 1'b1);
    `CHK("rx gear", 1'b0, rx_ctl.gearing_reset)
  endtask : updates

  task align_run;
    xfer(1'b1, ddr_startup_pkg::CTRL_OFFSET, 32'h00000010);
    xfer(1'b1, ddr_startup_pkg::CMD_OFFSET, 32'h00000004);
    wait_bit(5, 1'b1);
    `CHK("locks", 2'b11, {align_ctl.bit_lock, align_ctl.word_lock})
    `CHK("window", 4'h8, align_ctl.window_size)
    `CHK("word", ddr_startup_pkg::WORD_TARGET, clw)
    `CHK("sense", 1'b0, align_ctl.rotation_sense)
    // Restart without lock must be ignored, then a locked restart reruns
    lock_en <= 1'b0;
    xfer(1'b1, ddr_startup_pkg::CMD_OFFSET, 32'h00000004);
    repeat (3) @(posedge hclk);
    `CHK("no lock kept", 1'b1, align_ctl.ready)
    lock_en <= 1'b1;
    xfer(1'b1, ddr_startup_pkg::CMD_OFFSET, 32'h00000004);
    wait_bit(5, 1'b0);
    wait_bit(5, 1'b1);
    `CHK("relock", 5'h11, {align_ctl.window_size, align_ctl.word_lock})
  endtask : align_run

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_reset();
    seq_startup();
    updates();
    align_run();
    tally_and_finish();
  end
endmodule : testbench
